// [interrupt_flag_enable_logic.sv]
/*
 * Interrupt flag and enable logic with an AXI4-Lite register slave.
 * Three sources: external edge pin, upper four port pins, comparator.
 * Assumes all pin inputs are synchronous to clk and one AXI master
 * with at most one write and one read under way.
 */
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none

// Operation
// - a rising edge on the external pin sets a flag that stays until software clears it.
// - any change on the upper four port pins sets a sticky port flag.
// - the port flag stays zero while no upper port pin changes and no control write sets bit 0.
// - the control register answers at two addresses sharing one store.
// - bit 6 of the peripheral enable register enables the comparator.
// - the other peripheral enable bits read zero and ignore writes.
// - flags set on their event regardless of any enable.
// - bit 7 of the control register gates the request to the core, coreIrqReq; irq ignores it.
// - bit 6 of the peripheral flag register flags a comparator change.
module interrupt_flag_enable_logic
   import irq_flag_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // axi4-lite write address
   input wire logic awvalid,
   output logic awready,
   input wire logic [irq_flag_pkg::ADDR_W-1:0] awaddr,
   // axi4-lite write data
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   // axi4-lite write response
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   // axi4-lite read address
   input wire logic arvalid,
   output logic arready,
   input wire logic [irq_flag_pkg::ADDR_W-1:0] araddr,
   // axi4-lite read data
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   // interrupt sources
   input wire logic extEdgePin,
   input wire logic [irq_flag_pkg::NUM_PORT_PINS-1:0] upperPortPins,
   input wire logic comparatorOut,
   // interrupt outputs
   output logic coreIrqReq,
   output logic irq
);
   import irq_flag_pkg::*;

   // ****************************************************************
   // state
   // ****************************************************************
   typedef struct packed {
      logic awreadyR;
      logic wreadyR;
      logic awHeld;
      logic wHeld;
      logic [ADDR_W-1:0] awAddr;
      logic [7:0] wByte;
      logic wLane0;
      logic bvalidR;
      logic [1:0] brespR;
      logic arreadyR;
      logic rvalidR;
      logic [31:0] rdataR;
      logic [1:0] rrespR;
      logic globalIrqEnable;
      logic extFlag;
      logic portFlag;
      logic extEnable;
      logic portEnable;
      logic comparatorIrqEnable;
      logic comparatorIrqFlag;
      logic [NUM_SRC-1:0] status;
      logic [NUM_SRC-1:0] mask;
      logic irqR;
      logic coreIrqR;
   } ctl_state_t;

   ctl_state_t s_reg;
   ctl_state_t s_next;
   // ****************************************************************
   // source event detection
   // ****************************************************************
   logic [NUM_WATCHED-1:0] watched;
   logic [NUM_WATCHED-1:0] changed;
   logic [NUM_WATCHED-1:0] rose;
   logic extEvent;
   logic portEvent;
   logic cmpEvent;

   // one detector for all watched pins keeps history in one place
   assign watched = {comparatorOut, extEdgePin, upperPortPins};

   change_detect #(
      .WIDTH(NUM_WATCHED)
   ) u_detect (
      .clk(clk),
      .rst(rst),
      .sense(watched),
      .changed(changed),
      .rose(rose)
   );

   // rising edge on the pin, any change on port or comparator
   assign extEvent = rose[NUM_PORT_PINS];
   assign portEvent = |changed[NUM_PORT_PINS-1:0];
   assign cmpEvent = changed[NUM_PORT_PINS+1];

   // ****************************************************************
   // bus decode helpers
   // ****************************************************************
   logic awTake;
   logic wTake;
   logic haveAw;
   logic haveW;
   logic doWrite;
   logic [ADDR_W-1:0] wrAddr;
   logic [7:0] wrByte;
   logic wrLane0;
   logic wrHit;
   logic arTake;
   logic rdHit;
   logic [31:0] rdWord;
   logic wrControl;
   logic wrPeriphEn;
   logic wrPeriphFlag;
   logic wrSourceEn;
   logic wrMask;
   logic rdStatus;

   // handshakes and merged write address/data from bus or holding
   assign awTake = awvalid & s_reg.awreadyR;
   assign wTake = wvalid & s_reg.wreadyR;
   assign haveAw = s_reg.awHeld | awTake;
   assign haveW = s_reg.wHeld | wTake;
   assign doWrite = haveAw & haveW & ~s_reg.bvalidR;
   assign wrAddr = s_reg.awHeld ? s_reg.awAddr : awaddr;
   assign wrByte = s_reg.wHeld ? s_reg.wByte : wdata[7:0];
   assign wrLane0 = s_reg.wHeld ? s_reg.wLane0 : wstrb[0];
   assign arTake = arvalid & s_reg.arreadyR;

   // write address decode; upper byte lanes hold nothing
   always_comb
   begin
      wrControl = 1'b0;
      wrPeriphEn = 1'b0;
      wrPeriphFlag = 1'b0;
      wrSourceEn = 1'b0;
      wrMask = 1'b0;
      wrHit = 1'b1;
      if (wrAddr == ADDR_CONTROL_LO || wrAddr == ADDR_CONTROL_HI)
      begin
         wrControl = doWrite & wrLane0;
      end
      else if (wrAddr == ADDR_PERIPH_EN)
      begin
         wrPeriphEn = doWrite & wrLane0;
      end
      else if (wrAddr == ADDR_PERIPH_FLAG)
      begin
         wrPeriphFlag = doWrite & wrLane0;
      end
      else if (wrAddr == ADDR_SOURCE_EN)
      begin
         wrSourceEn = doWrite & wrLane0;
      end
      else if (wrAddr == ADDR_IRQ_MASK)
      begin
         wrMask = doWrite & wrLane0;
      end
      else if (wrAddr == ADDR_IRQ_STATUS)
      begin
         wrHit = 1'b1; // read-only, write accepted and dropped
      end
      else
      begin
         wrHit = 1'b0;
      end
   end

   // read address decode; unimplemented bits stay zero
   always_comb
   begin
      rdWord = 32'h0;
      rdHit = 1'b1;
      rdStatus = 1'b0;
      if (araddr == ADDR_CONTROL_LO || araddr == ADDR_CONTROL_HI)
      begin
         rdWord[BIT_GLOBAL_EN] = s_reg.globalIrqEnable;
         rdWord[BIT_EXT_FLAG] = s_reg.extFlag;
         rdWord[BIT_PORT_FLAG] = s_reg.portFlag;
      end
      else if (araddr == ADDR_PERIPH_EN)
      begin
         rdWord[BIT_CMP] = s_reg.comparatorIrqEnable;
      end
      else if (araddr == ADDR_PERIPH_FLAG)
      begin
         rdWord[BIT_CMP] = s_reg.comparatorIrqFlag;
      end
      else if (araddr == ADDR_SOURCE_EN)
      begin
         rdWord[BIT_SRC_EXT] = s_reg.extEnable;
         rdWord[BIT_SRC_PORT] = s_reg.portEnable;
      end
      else if (araddr == ADDR_IRQ_STATUS)
      begin
         rdWord[NUM_SRC-1:0] = s_reg.status;
         rdStatus = arTake;
      end
      else if (araddr == ADDR_IRQ_MASK)
      begin
         rdWord[NUM_SRC-1:0] = s_reg.mask;
      end
      else
      begin
         rdHit = 1'b0;
      end
   end

   // ****************************************************************
   // next state
   // ****************************************************************
   logic [NUM_SRC-1:0] events;
   logic reqNext;

   // events of this cycle, then one next-state pass over every field
   assign events = {cmpEvent, portEvent, extEvent};
   always_comb
   begin
      s_next = s_reg;
      // write channel holding: keep whichever half arrived first
      if (awTake & ~doWrite)
      begin
         s_next.awHeld = 1'b1;
         s_next.awAddr = awaddr;
      end
      if (wTake & ~doWrite)
      begin
         s_next.wHeld = 1'b1;
         s_next.wByte = wdata[7:0];
         s_next.wLane0 = wstrb[0];
      end
      if (doWrite)
      begin
         s_next.awHeld = 1'b0;
         s_next.wHeld = 1'b0;
         s_next.bvalidR = 1'b1;
         s_next.brespR = wrHit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_reg.bvalidR & bready)
      begin
         s_next.bvalidR = 1'b0;
      end
      // a new half is taken only while no response is waiting
      s_next.awreadyR = ~s_next.awHeld & ~s_next.bvalidR;
      s_next.wreadyR = ~s_next.wHeld & ~s_next.bvalidR;

      // read channel: answer one cycle after the address is taken
      if (arTake)
      begin
         s_next.rvalidR = 1'b1;
         s_next.rdataR = rdWord;
         s_next.rrespR = rdHit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_reg.rvalidR & rready)
      begin
         s_next.rvalidR = 1'b0;
      end
      s_next.arreadyR = ~s_next.rvalidR;

      // software writes to enables, flags and mask; unimplemented bits dropped
      if (wrControl)
      begin
         s_next.globalIrqEnable = wrByte[BIT_GLOBAL_EN];
         s_next.extFlag = wrByte[BIT_EXT_FLAG];
         s_next.portFlag = wrByte[BIT_PORT_FLAG];
      end
      if (wrPeriphEn)
      begin
         s_next.comparatorIrqEnable = wrByte[BIT_CMP];
      end
      if (wrPeriphFlag)
      begin
         s_next.comparatorIrqFlag = wrByte[BIT_CMP];
      end
      if (wrSourceEn)
      begin
         s_next.extEnable = wrByte[BIT_SRC_EXT];
         s_next.portEnable = wrByte[BIT_SRC_PORT];
      end
      if (wrMask)
      begin
         s_next.mask = wrByte[NUM_SRC-1:0];
      end

      // events set flags after the write, so a set beats a clear
      if (extEvent)
      begin
         s_next.extFlag = 1'b1;
      end
      if (portEvent)
      begin
         s_next.portFlag = 1'b1;
      end
      if (cmpEvent)
      begin
         s_next.comparatorIrqFlag = 1'b1;
      end

      // status is cleared by its own read, again losing to a new event
      if (rdStatus)
      begin
         s_next.status = RST_SRC;
      end
      s_next.status = s_next.status | events;

      // request toward the core, gated by the global enable
      reqNext = (s_next.extFlag & s_next.extEnable)
         | (s_next.portFlag & s_next.portEnable)
         | (s_next.comparatorIrqFlag & s_next.comparatorIrqEnable);
      s_next.coreIrqR = s_next.globalIrqEnable & reqNext;
      s_next.irqR = |(s_next.status & s_next.mask);
   end

   // ****************************************************************
   // state register
   // ****************************************************************
   // reset gives constants only; every enable starts cleared
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         s_reg <= '0;
         s_reg.comparatorIrqEnable <= RST_BIT;
      end
      else
      begin
         s_reg <= s_next;
      end
   end

   // ****************************************************************
   // outputs, all straight from flops
   // ****************************************************************
   assign awready = s_reg.awreadyR;
   assign wready = s_reg.wreadyR;
   assign bvalid = s_reg.bvalidR;
   assign bresp = s_reg.brespR;
   assign arready = s_reg.arreadyR;
   assign rvalid = s_reg.rvalidR;
   assign rdata = s_reg.rdataR;
   assign rresp = s_reg.rrespR;
   assign coreIrqReq = s_reg.coreIrqR;
   assign irq = s_reg.irqR;

endmodule : interrupt_flag_enable_logic

`default_nettype wire

// [irq_flag_pkg.sv]
/*
 * Constants shared by the interrupt flag and enable logic: register
 * indices, byte addresses, field positions, reset values, bus answers.
 * Assumes a byte-addressed register bus where each register takes one
 * aligned 32-bit word at four times its index.
 */
package irq_flag_pkg;

   // ****************************************************************
   // register indices and byte addresses
   // ****************************************************************
   localparam int ADDR_W = 12;
   localparam logic [9:0] IDX_CONTROL_LO = 10'h00B;
   localparam logic [9:0] IDX_CONTROL_HI = 10'h08B;
   localparam logic [9:0] IDX_PERIPH_EN = 10'h08C;
   localparam logic [9:0] IDX_PERIPH_FLAG = 10'h00C;
   localparam logic [9:0] IDX_SOURCE_EN = 10'h040;
   localparam logic [9:0] IDX_IRQ_STATUS = 10'h041;
   localparam logic [9:0] IDX_IRQ_MASK = 10'h042;
   localparam logic [11:0] ADDR_CONTROL_LO = {IDX_CONTROL_LO, 2'b00};
   localparam logic [11:0] ADDR_CONTROL_HI = {IDX_CONTROL_HI, 2'b00};
   localparam logic [11:0] ADDR_PERIPH_EN = {IDX_PERIPH_EN, 2'b00};
   localparam logic [11:0] ADDR_PERIPH_FLAG = {IDX_PERIPH_FLAG, 2'b00};
   localparam logic [11:0] ADDR_SOURCE_EN = {IDX_SOURCE_EN, 2'b00};
   localparam logic [11:0] ADDR_IRQ_STATUS = {IDX_IRQ_STATUS, 2'b00};
   localparam logic [11:0] ADDR_IRQ_MASK = {IDX_IRQ_MASK, 2'b00};

   // ****************************************************************
   // field positions
   // ****************************************************************
   localparam int BIT_GLOBAL_EN = 7;
   localparam int BIT_EXT_FLAG = 1;
   localparam int BIT_PORT_FLAG = 0;
   localparam int BIT_CMP = 6;
   localparam int BIT_SRC_EXT = 0;
   localparam int BIT_SRC_PORT = 1;
   localparam int BIT_SRC_CMP = 2;
   localparam int NUM_SRC = 3;
   localparam int NUM_PORT_PINS = 4;
   localparam int NUM_WATCHED = 6;

   // ****************************************************************
   // reset values and bus answers
   // ****************************************************************
   localparam logic RST_BIT = 1'b0;
   localparam logic [NUM_SRC-1:0] RST_SRC = 3'h0;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : irq_flag_pkg

// [change_detect.sv]
/*
 * Per-bit change and rising-edge detector for synchronous inputs.
 * Assumes inputs are already synchronous to clk; the first cycle after
 * reset only loads the history, so no change is reported for it.
 */
`timescale 1ns/1ps
`default_nettype none

module change_detect #(
   parameter int WIDTH = 6
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // watched inputs
   input wire logic [WIDTH-1:0] sense,
   // per-bit one-cycle pulses
   output logic [WIDTH-1:0] changed,
   output logic [WIDTH-1:0] rose
);

   typedef struct packed {
      logic primed;
      logic [WIDTH-1:0] prev;
   } det_state_t;

   det_state_t det_reg;
   det_state_t det_next;

   // history follows the inputs every cycle
   always_comb
   begin
      det_next = det_reg;
      det_next.primed = 1'b1;
      det_next.prev = sense;
   end

   // reset to constants only; priming hides the unknown first sample
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         det_reg <= '0;
      end
      else
      begin
         det_reg <= det_next;
      end
   end

   // pulses valid only once history holds a real sample
   assign changed = det_reg.primed ? (sense ^ det_reg.prev) : '0;
   assign rose = det_reg.primed ? (sense & ~det_reg.prev) : '0;

endmodule : change_detect

`default_nettype wire

// [pin_source_model.sv]
/*
 * Model of the pins that feed the three interrupt sources.
 * Assumes pins are sampled on the rising edge of clk.
 */
`timescale 1ns/1ps
`default_nettype none
module pin_source_model (
   // clock
   input wire logic clk,
   // source pins
   output logic extEdgePin,
   output logic [irq_flag_pkg::NUM_PORT_PINS-1:0] upperPortPins,
   output logic comparatorOut
);
   import irq_flag_pkg::*;
   // ********************
   // pin events
   // ********************
   // pins rest low, so the first level after reset is known
   initial
   begin
      extEdgePin = 1'b0;
      upperPortPins = '0;
      comparatorOut = 1'b0;
   end
   // rise then fall; only the rise counts as an event
   task automatic pulseExt();
      @(posedge clk);
      extEdgePin <= 1'b1;
      @(posedge clk);
      extEdgePin <= 1'b0;
   endtask : pulseExt
   task automatic togglePort(input logic [NUM_PORT_PINS-1:0] m);
      @(posedge clk);
      upperPortPins <= upperPortPins ^ m;
   endtask : togglePort
   task automatic toggleCmp();
      @(posedge clk);
      comparatorOut <= ~comparatorOut;
   endtask : toggleCmp
endmodule : pin_source_model
`default_nettype wire

// [irq_flag_monitor.sv]
/*
 * Checker for the interrupt flag and enable logic.
 * Assumes it is bound to the top module and sees only its ports.
 */
`timescale 1ns/1ps
`default_nettype none
module irq_flag_monitor (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // bus handshakes
   input wire logic awvalid,
   input wire logic awready,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic bvalid,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic [irq_flag_pkg::ADDR_W-1:0] araddr,
   input wire logic rvalid,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp,
   // request
   input wire logic coreIrqReq
);
   import irq_flag_pkg::*;
   logic [ADDR_W-1:0] lastAr;
   logic isCtrl;
   logic isMapped;
   // ********************
   // helpers
   // ********************
   // keep the read address, since the answer comes a cycle later
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         lastAr <= '0;
      else if (arvalid && arready)
         lastAr <= araddr;
   end
   assign isCtrl = lastAr == ADDR_CONTROL_LO || lastAr == ADDR_CONTROL_HI;
   assign isMapped = isCtrl || lastAr inside {ADDR_PERIPH_EN,
      ADDR_PERIPH_FLAG, ADDR_SOURCE_EN, ADDR_IRQ_STATUS, ADDR_IRQ_MASK};
   // ********************
   // properties
   // ********************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   AST_B_AFTER_WRITE: assert property (awvalid && awready && wvalid
      && wready |=> bvalid) else $error("write answer not on time");
   AST_R_AFTER_READ: assert property (arvalid && arready |=> rvalid
      && !arready) else $error("read answer not on time");
   AST_B_BLOCKS_WRITE: assert property (bvalid |-> !awready && !wready)
      else $error("write taken while answer pending");
   AST_CTRL_UNUSED: assert property (rvalid && isCtrl |->
      (rdata & 32'hFFFFFF7C) == 32'h0 && rresp == RESP_OKAY)
      else $error("control read shows unused bits");
   AST_PEN_UNUSED: assert property (rvalid &&
      lastAr == ADDR_PERIPH_EN |-> (rdata & 32'hFFFFFFBF) == 32'h0)
      else $error("enable read shows unused bits");
   AST_PFLAG_UNUSED: assert property (rvalid &&
      lastAr == ADDR_PERIPH_FLAG |-> (rdata & 32'hFFFFFFBF) == 32'h0)
      else $error("flag read shows unused bits");
   AST_GIE_GATE: assert property ($rose(rvalid) && isCtrl &&
      !$rose(bvalid) && !rdata[BIT_GLOBAL_EN] |-> !coreIrqReq)
      else $error("request while global enable clear");
   AST_UNMAPPED: assert property (rvalid && !isMapped |->
      rresp == RESP_SLVERR && rdata == 32'h0)
      else $error("unmapped read not refused");
   cover property (rvalid && !isMapped);
   cover property (rvalid && isCtrl && rdata[BIT_GLOBAL_EN] && coreIrqReq);
   cover property ($rose(coreIrqReq));
endmodule : irq_flag_monitor
bind interrupt_flag_enable_logic irq_flag_monitor mon (.clk(clk),
   .rst(rst), .awvalid(awvalid), .awready(awready), .wvalid(wvalid),
   .wready(wready), .bvalid(bvalid), .arvalid(arvalid),
   .arready(arready), .araddr(araddr), .rvalid(rvalid), .rdata(rdata),
   .rresp(rresp), .coreIrqReq(coreIrqReq));
`default_nettype wire

// [tb_top.sv]
/*
 * Testbench: register sequences over the bus and pin events.
 * Assumes the pin model and the bound checker are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import irq_flag_pkg::*;
   logic clk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, extEdgePin, comparatorOut;
   logic coreIrqReq, irq;
   logic [ADDR_W-1:0] awaddr, araddr;
   logic [31:0] wdata, rdata, lastData;
   logic [3:0] wstrb;
   logic [NUM_PORT_PINS-1:0] upperPortPins;
   logic [1:0] bresp, rresp, lastResp;
   int num_errors, checked;
   // ********************
   // clock, design, pins
   // ********************
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   interrupt_flag_enable_logic dut (.clk(clk), .rst(rst),
      .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
      .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
      .bvalid(bvalid), .bready(bready), .bresp(bresp),
      .arvalid(arvalid), .arready(arready), .araddr(araddr),
      .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
      .extEdgePin(extEdgePin), .upperPortPins(upperPortPins),
      .comparatorOut(comparatorOut), .coreIrqReq(coreIrqReq), .irq(irq));
   pin_source_model pins (.clk(clk), .extEdgePin(extEdgePin),
      .upperPortPins(upperPortPins), .comparatorOut(comparatorOut));
   // ********************
   // tasks
   // ********************
   task automatic finish_test();
      $display("mismatches %0d of %0d checks", num_errors, checked);
      if (num_errors == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : finish_test
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         $display("wrong value at %0t: seen %h expected %h", $time, seen,
            exp);
         num_errors++;
      end
   endtask : check
   // both channels offered at once; each dropped once taken
   task automatic axiWrite(input logic [ADDR_W-1:0] a, input logic [7:0] d);
      int n;
      @(posedge clk);
      awvalid <= 1'b1;
      awaddr <= a;
      wvalid <= 1'b1;
      wdata <= {24'h000000, d};
      wstrb <= 4'hF;
      bready <= 1'b1;
      for (n = 0; n < 50; n++)
      begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      bready <= 1'b0;
      lastResp = bresp;
      if (n == 50) num_errors++;
      if (n == 50) finish_test();
   endtask : axiWrite
   task automatic rdChk(input logic [ADDR_W-1:0] a, input logic [7:0] d,
      input logic [1:0] r);
      int n;
      @(posedge clk);
      arvalid <= 1'b1;
      araddr <= a;
      rready <= 1'b1;
      for (n = 0; n < 50; n++)
      begin
         @(posedge clk);
         if (arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      rready <= 1'b0;
      lastData = rdata;
      lastResp = rresp;
      if (n == 50) num_errors++;
      if (n == 50) finish_test();
      check(lastData, {24'h000000, d});
      check({30'h0, lastResp}, {30'h0, r});
   endtask : rdChk
   // both interrupt outputs at once
   task automatic chkIrq(input logic req, input logic lvl);
      check({30'h0, coreIrqReq, irq}, {30'h0, req, lvl});
   endtask : chkIrq
   // ********************
   // sequence
   // ********************
   initial
   begin
      rst = 1'b1;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      {awaddr, araddr, wdata, wstrb} = '0;
      num_errors = 0;
      checked = 0;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      rdChk(ADDR_CONTROL_LO, 8'h00, RESP_OKAY);
      rdChk(ADDR_PERIPH_EN, 8'h00, RESP_OKAY);
      rdChk(ADDR_PERIPH_FLAG, 8'h00, RESP_OKAY);
      // all sources fire while every enable is still clear
      pins.pulseExt();
      pins.togglePort(4'h8);
      pins.toggleCmp();
      repeat (3) @(posedge clk);
      chkIrq(1'b0, 1'b0);
      rdChk(ADDR_CONTROL_HI, 8'h03, RESP_OKAY);
      rdChk(ADDR_PERIPH_FLAG, 8'h40, RESP_OKAY);
      rdChk(ADDR_CONTROL_LO, 8'h03, RESP_OKAY);
      rdChk(ADDR_IRQ_STATUS, 8'h07, RESP_OKAY);
      rdChk(ADDR_IRQ_STATUS, 8'h00, RESP_OKAY);
      // stale flags go before any source is enabled
      axiWrite(ADDR_CONTROL_LO, 8'h00);
      axiWrite(ADDR_PERIPH_FLAG, 8'h00);
      rdChk(ADDR_CONTROL_HI, 8'h00, RESP_OKAY);
      rdChk(ADDR_CONTROL_LO, 8'h00, RESP_OKAY);
      axiWrite(ADDR_PERIPH_EN, 8'hFF);
      rdChk(ADDR_PERIPH_EN, 8'h40, RESP_OKAY);
      axiWrite(ADDR_PERIPH_EN, 8'hBF);
      rdChk(ADDR_PERIPH_EN, 8'h00, RESP_OKAY);
      // enables on, then the global bit opens and closes the gate
      axiWrite(ADDR_SOURCE_EN, 8'h03);
      axiWrite(ADDR_PERIPH_EN, 8'h40);
      axiWrite(ADDR_CONTROL_HI, 8'h80);
      check({30'h0, lastResp}, {30'h0, RESP_OKAY});
      rdChk(ADDR_CONTROL_LO, 8'h80, RESP_OKAY);
      chkIrq(1'b0, 1'b0);
      pins.toggleCmp();
      repeat (3) @(posedge clk);
      chkIrq(1'b1, 1'b0);
      axiWrite(ADDR_PERIPH_EN, 8'h00);
      chkIrq(1'b0, 1'b0);
      axiWrite(ADDR_IRQ_MASK, 8'h04);
      chkIrq(1'b0, 1'b1);
      axiWrite(ADDR_CONTROL_LO, 8'h00);
      axiWrite(ADDR_PERIPH_EN, 8'h40);
      pins.togglePort(4'h1);
      repeat (3) @(posedge clk);
      chkIrq(1'b0, 1'b1);
      rdChk(ADDR_CONTROL_HI, 8'h01, RESP_OKAY);
      axiWrite(ADDR_CONTROL_HI, 8'h81);
      chkIrq(1'b1, 1'b1);
      rdChk(ADDR_IRQ_STATUS, 8'h06, RESP_OKAY);
      chkIrq(1'b1, 1'b0);
      // unmapped place is refused both ways
      rdChk(12'h3FC, 8'h00, RESP_SLVERR);
      axiWrite(12'h3FC, 8'hFF);
      check({30'h0, lastResp}, {30'h0, RESP_SLVERR});
      finish_test();
   end
endmodule : tb_top
`default_nettype wire
